// ==== verilog/dsseq_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the data set sequencer
`ifndef DSSEQ_DEFINES_SVH
`define DSSEQ_DEFINES_SVH

`define DSSEQ_REF_CLK_HZ       40000000
`define DSSEQ_TICK_MS          1
`define DSSEQ_TICK_CYC         ((`DSSEQ_REF_CLK_HZ / 1000) * `DSSEQ_TICK_MS)

`define DSSEQ_OFF_CTRL         12'h000
`define DSSEQ_OFF_STATUS       12'h004
`define DSSEQ_OFF_ACCEL        12'h008
`define DSSEQ_OFF_DECEL        12'h00C
`define DSSEQ_OFF_GEAR_NUM     12'h010
`define DSSEQ_OFF_GEAR_DEN     12'h014
`define DSSEQ_OFF_SET_BASE     12'h100
`define DSSEQ_SET_STRIDE_SH    4
`define DSSEQ_SET_W_CFG        2'h0
`define DSSEQ_SET_W_VAL1       2'h1
`define DSSEQ_SET_W_VAL2       2'h2
`define DSSEQ_SET_W_NEXT       2'h3
`define DSSEQ_SET_PAGE         4'h1

`define DSSEQ_MODE_SEQ         4'hC
`define DSSEQ_START_SINGLE     4'h0

`define DSSEQ_ACC_RST          16'h2710
`define DSSEQ_DEC_RST          16'h2710
`define DSSEQ_GNUM_RST         16'h0002
`define DSSEQ_GDEN_RST         16'h0001

`define DSSEQ_VAL_RISE         16'h0000
`define DSSEQ_VAL_FALL         16'h0001
`define DSSEQ_VAL_BOTH         16'h0002
`define DSSEQ_VAL_HIGH         16'h0003
`define DSSEQ_VAL_LOW          16'h0004

`endif

// ==== verilog/dsseq_pkg.sv ====
// Types shared by the data set sequencer
package dsseq_pkg;
    typedef enum logic [1:0] {DSSEQ_INVALID, DSSEQ_ABS, DSSEQ_REL, DSSEQ_RSVD} dsseq_kind_t;
    typedef enum logic [3:0] {DSSEQ_C_NONE, DSSEQ_C_DELAY, DSSEQ_C_EDGE, DSSEQ_C_LEVEL} dsseq_cond_t;
    typedef enum logic [3:0] {DSSEQ_J_NONE, DSSEQ_J_AND, DSSEQ_J_OR} dsseq_join_t;
    typedef enum logic [1:0] {DSSEQ_IDLE, DSSEQ_LOAD, DSSEQ_RUN} dsseq_state_t;
endpackage

// ==== verilog/dsseq_top.sv ====
// Data set step sequencer with APB register access
//
// Contract
// - Sequence runs only when control-mode field holds the motion sequence code.
// - Startup-manner field zero selects single data set startup.
// - Set type 0 invalid, 1 absolute move, 2 relative move.
// - First condition none starts next set at once, second ignored.
// - Delay condition waits its value in milliseconds, 0 to 65535.
// - First condition edge advances on the selected step input edge.
// - First condition level advances while step input holds selected level.
// - Second condition supports none, delay, edge or level using value two.
// - Edge value 0 rising, 1 falling, 2 either; others invalid.
// - Level value 3 high, 4 low; others invalid.
// - Conjunction 0 ignores second, 1 needs both, 2 needs either.
// - Each set names a next set from 0 to 7.
// - Acceleration and deceleration 1 to 60000, default 10000.
// - Start input high allows motion; low stops it.
// - Eight data sets, each with type, conditions, target and next set.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
`include "dsseq_defines.svh"

module dsseq_top #(
    parameter int TICK_CYC = `DSSEQ_TICK_CYC,
    parameter int NSETS    = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        seq_start,
    input  wire logic        seq_step,
    output logic             move_go,
    output logic             move_run,
    output logic [1:0]       move_kind,
    output logic [2:0]       move_set,
    output logic [31:0]      move_target,
    output logic [15:0]      move_accel,
    output logic [15:0]      move_decel,
    output logic [15:0]      move_gear_num,
    output logic [15:0]      move_gear_den,
    input  wire logic        move_done
);

    // Per-set storage
    logic [15:0] set_cfg_ff  [NSETS];
    logic [15:0] set_val1_ff [NSETS];
    logic [15:0] set_val2_ff [NSETS];
    logic [2:0]  set_next_ff [NSETS];
    logic [31:0] set_tgt_ff  [NSETS];
    logic [15:0] ctrl_ff;
    logic [15:0] acc_ff, dec_ff, gnum_ff, gden_ff;
    logic [2:0]  cur_ff;
    logic [15:0] ms_ff;
    logic [31:0] tick_ff;
    logic        step_s1_ff, step_s2_ff, step_s3_ff, step_ok_ff, step_prev_ff;
    logic        start_s1_ff, start_s2_ff, start_s3_ff, start_ok_ff, start_prev_ff;
    logic        move_go_ff;
    logic        rd_err;
    logic [31:0] rd_data;
    logic        wr_en;
    logic        adv;
    logic        seq_en;
    logic        rise, fall;
    dsseq_pkg::dsseq_state_t st_ff;

    // Checks one condition against its value
    function automatic logic cond_met(input logic [3:0] ctype, input logic [15:0] val,
                                      input logic [15:0] ms, input logic r, input logic f,
                                      input logic lvl);
        logic m;
        m = 1'b0;
        case (ctype)
            4'h0: m = 1'b1;
            4'h1: m = (ms >= val);
            4'h2: m = (val == `DSSEQ_VAL_RISE && r) || (val == `DSSEQ_VAL_FALL && f) ||
                      (val == `DSSEQ_VAL_BOTH && (r || f));
            4'h3: m = (val == `DSSEQ_VAL_HIGH && lvl) || (val == `DSSEQ_VAL_LOW && !lvl);
            default: m = 1'b0;
        endcase
        return m;
    endfunction

    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && rd_err;

    // Step and start inputs: three stages, change accepted when last two agree
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            step_s1_ff  <= 1'b0;
            step_s2_ff  <= 1'b0;
            step_s3_ff  <= 1'b0;
            step_ok_ff  <= 1'b0;
            start_s1_ff <= 1'b0;
            start_s2_ff <= 1'b0;
            start_s3_ff <= 1'b0;
            start_ok_ff <= 1'b0;
        end
        else
        begin
            step_s1_ff  <= seq_step;
            step_s2_ff  <= step_s1_ff;
            step_s3_ff  <= step_s2_ff;
            start_s1_ff <= seq_start;
            start_s2_ff <= start_s1_ff;
            start_s3_ff <= start_s2_ff;
            if (step_s2_ff == step_s3_ff)
                step_ok_ff <= step_s3_ff;
            if (start_s2_ff == start_s3_ff)
                start_ok_ff <= start_s3_ff;
        end
    end

    // Edge history of filtered inputs
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            step_prev_ff  <= 1'b0;
            start_prev_ff <= 1'b0;
        end
        else
        begin
            step_prev_ff  <= step_ok_ff;
            start_prev_ff <= start_ok_ff;
        end
    end

    assign rise = step_ok_ff && !step_prev_ff;
    assign fall = !step_ok_ff && step_prev_ff;

    // mode code and single set startup
    assign seq_en = (ctrl_ff[7:4] == `DSSEQ_MODE_SEQ) && (ctrl_ff[3:0] == `DSSEQ_START_SINGLE);

    // Global registers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_ff <= 16'h0000;
            acc_ff  <= `DSSEQ_ACC_RST;
            dec_ff  <= `DSSEQ_DEC_RST;
            gnum_ff <= `DSSEQ_GNUM_RST;
            gden_ff <= `DSSEQ_GDEN_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                `DSSEQ_OFF_CTRL: ctrl_ff <= pwdata[15:0];
                `DSSEQ_OFF_ACCEL:
                    if (pwdata[15:0] != 16'h0000 && pwdata[15:0] <= 16'hEA60)
                        acc_ff <= pwdata[15:0];
                `DSSEQ_OFF_DECEL:
                    if (pwdata[15:0] != 16'h0000 && pwdata[15:0] <= 16'hEA60)
                        dec_ff <= pwdata[15:0];
                `DSSEQ_OFF_GEAR_NUM:
                    if (pwdata[15:0] != 16'h0000)
                        gnum_ff <= pwdata[15:0];
                `DSSEQ_OFF_GEAR_DEN:
                    if (pwdata[15:0] != 16'h0000)
                        gden_ff <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < NSETS; i++)
            begin
                set_cfg_ff[i]  <= 16'h0000;
                set_val1_ff[i] <= 16'h0000;
                set_val2_ff[i] <= 16'h0000;
                set_next_ff[i] <= 3'h0;
                set_tgt_ff[i]  <= 32'h00000000;
            end
        end
        else if (wr_en && paddr[11:8] == `DSSEQ_SET_PAGE && paddr[7] == 1'b0)
        begin
            case (paddr[3:2])
                `DSSEQ_SET_W_CFG:  set_cfg_ff[paddr[6:4]]  <= pwdata[15:0];
                `DSSEQ_SET_W_VAL1: set_val1_ff[paddr[6:4]] <= pwdata[15:0];
                `DSSEQ_SET_W_VAL2: set_val2_ff[paddr[6:4]] <= pwdata[15:0];
                default:
                begin
                    set_next_ff[paddr[6:4]] <= pwdata[2:0];
                    set_tgt_ff[paddr[6:4]]  <= {pwdata[31:8], 8'h00};
                end
            endcase
        end
    end

    // Combined advance condition of the current set
    always_comb
    begin
        logic c1, c2;
        logic [15:0] cfg;
        c1  = 1'b0;
        c2  = 1'b0;
        cfg = set_cfg_ff[cur_ff];
        c1  = cond_met(cfg[3:0], set_val1_ff[cur_ff], ms_ff, rise, fall, step_ok_ff);
        c2  = cond_met(cfg[7:4], set_val2_ff[cur_ff], ms_ff, rise, fall, step_ok_ff);
        adv = 1'b0;
        if (cfg[3:0] == 4'h0)
            adv = 1'b1;
        else
        begin
            case (cfg[11:8])
                4'h0:    adv = c1;
                4'h1:    adv = c1 && c2;
                4'h2:    adv = c1 || c2;
                default: adv = 1'b0;
            endcase
        end
    end

    // Sequence state machine
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff      <= dsseq_pkg::DSSEQ_IDLE;
            cur_ff     <= 3'h0;
            move_go_ff <= 1'b0;
        end
        else
        begin
            move_go_ff <= 1'b0;
            case (st_ff)
                dsseq_pkg::DSSEQ_IDLE:
                    if (seq_en && start_ok_ff && !start_prev_ff)
                    begin
                        cur_ff <= 3'h0;
                        st_ff  <= dsseq_pkg::DSSEQ_LOAD;
                    end
                dsseq_pkg::DSSEQ_LOAD:
                begin
                    if (set_cfg_ff[cur_ff][13:12] == 2'h0 || set_cfg_ff[cur_ff][13:12] == 2'h3)
                        st_ff <= dsseq_pkg::DSSEQ_IDLE;
                    else
                    begin
                        move_go_ff <= 1'b1;
                        st_ff      <= dsseq_pkg::DSSEQ_RUN;
                    end
                end
                dsseq_pkg::DSSEQ_RUN:
                    if (adv && move_done)
                    begin
                        cur_ff <= set_next_ff[cur_ff];
                        st_ff  <= dsseq_pkg::DSSEQ_LOAD;
                    end
                default: st_ff <= dsseq_pkg::DSSEQ_IDLE;
            endcase
            if (!start_ok_ff || !seq_en)
                st_ff <= dsseq_pkg::DSSEQ_IDLE;
        end
    end

    // Millisecond timer, restarted at each set load
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_ff <= 32'h00000000;
            ms_ff   <= 16'h0000;
        end
        else if (st_ff != dsseq_pkg::DSSEQ_RUN)
        begin
            tick_ff <= 32'h00000000;
            ms_ff   <= 16'h0000;
        end
        else if (tick_ff == 32'(TICK_CYC - 1))
        begin
            tick_ff <= 32'h00000000;
            if (ms_ff != 16'hFFFF)
                ms_ff <= ms_ff + 16'h0001;
        end
        else
            tick_ff <= tick_ff + 32'h00000001;
    end

    // Motion outputs
    assign move_go       = move_go_ff;
    assign move_run      = (st_ff == dsseq_pkg::DSSEQ_RUN);
    assign move_kind     = set_cfg_ff[cur_ff][13:12];
    assign move_set      = cur_ff;
    assign move_target   = set_tgt_ff[cur_ff];
    assign move_accel    = acc_ff;
    assign move_decel    = dec_ff;
    assign move_gear_num = gnum_ff;
    assign move_gear_den = gden_ff;

    // Read mux
    always_comb
    begin
        rd_err  = 1'b0;
        rd_data = 32'h00000000;
        if (paddr[11:8] == `DSSEQ_SET_PAGE && paddr[7] == 1'b0)
        begin
            case (paddr[3:2])
                `DSSEQ_SET_W_CFG:  rd_data = {16'h0000, set_cfg_ff[paddr[6:4]]};
                `DSSEQ_SET_W_VAL1: rd_data = {16'h0000, set_val1_ff[paddr[6:4]]};
                `DSSEQ_SET_W_VAL2: rd_data = {16'h0000, set_val2_ff[paddr[6:4]]};
                default: rd_data = {set_tgt_ff[paddr[6:4]][31:8], 5'h00, set_next_ff[paddr[6:4]]};
            endcase
        end
        else
        begin
            case (paddr)
                `DSSEQ_OFF_CTRL:     rd_data = {16'h0000, ctrl_ff};
                `DSSEQ_OFF_STATUS:   rd_data = {25'h0000000, st_ff, cur_ff, step_ok_ff, start_ok_ff};
                `DSSEQ_OFF_ACCEL:    rd_data = {16'h0000, acc_ff};
                `DSSEQ_OFF_DECEL:    rd_data = {16'h0000, dec_ff};
                `DSSEQ_OFF_GEAR_NUM: rd_data = {16'h0000, gnum_ff};
                `DSSEQ_OFF_GEAR_DEN: rd_data = {16'h0000, gden_ff};
                default:             rd_err  = 1'b1;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_data;
    end

endmodule

// ==== verification/dsseq_properties.sv ====
// Concurrent checks on the sequencer ports
`timescale 1ns/10ps
module dsseq_props (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        seq_start,
    input wire logic        move_go,
    input wire logic        move_run,
    input wire logic [1:0]  move_kind,
    input wire logic [2:0]  move_set,
    input wire logic [15:0] move_accel,
    input wire logic [15:0] move_decel,
    input wire logic [15:0] move_gear_num,
    input wire logic [15:0] move_gear_den
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // Motion pulses and run level
    a_go_single: assert property (move_go |=> !move_go)
        else $error("move_go held longer than one cycle");
    a_go_after_load: assert property (move_go |-> !$past(move_run))
        else $error("move_go without a load cycle before it");
    a_run_with_go: assert property ($rose(move_run) |-> move_go)
        else $error("run started without move_go");
    a_start_stops: assert property (!seq_start [*8] |-> !move_run)
        else $error("still running with start low");
    a_kind_valid: assert property (move_go |-> move_kind inside {2'h1, 2'h2})
        else $error("invalid set type launched");
    a_set_held: assert property (move_run && $past(move_run) |-> $stable(move_set))
        else $error("set index changed while running");
    // Motion settings stay inside their ranges
    a_ramp_range: assert property (move_accel inside {[16'h0001:16'hEA60]} && move_decel inside {[16'h0001:16'hEA60]})
        else $error("ramp setting out of range");
    a_gear_nonzero: assert property (move_gear_num != 16'h0000 && move_gear_den != 16'h0000)
        else $error("gear value zero");
    // Register bus answers
    a_apb_ready: assert property (psel && penable |-> pready)
        else $error("access phase without pready");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
endmodule

bind dsseq_top dsseq_props chk_u (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .seq_start(seq_start),
    .move_go(move_go), .move_run(move_run), .move_kind(move_kind), .move_set(move_set),
    .move_accel(move_accel), .move_decel(move_decel), .move_gear_num(move_gear_num),
    .move_gear_den(move_gear_den));

// ==== verification/dsseq_host_model.sv ====
// Host controller and motion generator stand-in
`timescale 1ns/10ps
module dsseq_host_model #(
    parameter int LAG = 3
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic start_cmd,
    input wire logic step_cmd,
    input wire logic move_go,
    output logic     seq_start,
    output logic     seq_step,
    output logic     move_done
);
    logic     start_ff;
    logic     step_ff;
    int       lag_ff;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            start_ff <= 1'b0;
            step_ff  <= 1'b0;
        end
        else
        begin
            start_ff <= start_cmd;
            step_ff  <= step_cmd;
        end
    end

    // Motion completes LAG cycles after each launch
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            lag_ff <= 0;
        else if (move_go)
            lag_ff <= LAG;
        else if (lag_ff != 0)
            lag_ff <= lag_ff - 1;
    end

    assign seq_start = start_ff;
    assign seq_step  = step_ff;
    assign move_done = (lag_ff == 0) && !move_go;
endmodule

// ==== verification/dsseq_tb.sv ====
// Self-checking bench for the data set sequencer
`timescale 1ns/10ps
`include "dsseq_defines.svh"
module tb;
    logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
    logic        seq_start, seq_step, move_go, move_run, move_done, start_cmd, step_cmd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, move_target, rd;
    logic [1:0]  move_kind;
    logic [2:0]  move_set;
    logic [15:0] move_accel, move_decel, move_gear_num, move_gear_den;
    int          fails, samples_checked;

    dsseq_top #(.TICK_CYC(4), .NSETS(8)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_start(seq_start),
        .seq_step(seq_step), .move_go(move_go), .move_run(move_run), .move_kind(move_kind),
        .move_set(move_set), .move_target(move_target), .move_accel(move_accel),
        .move_decel(move_decel), .move_gear_num(move_gear_num),
        .move_gear_den(move_gear_den), .move_done(move_done));
    dsseq_host_model host_u (.ref_clk(ref_clk), .arst_n(arst_n), .start_cmd(start_cmd),
        .step_cmd(step_cmd), .move_go(move_go), .seq_start(seq_start),
        .seq_step(seq_step), .move_done(move_done));

    // 40 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task results;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge ref_clk);
            rd = prdata;
            er = pslverr;
            if (pready === 1'b1)
                break;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16)
        begin
            fails++;
            results();
        end
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    function logic [31:0] cf(input logic [1:0] k, input logic [3:0] j, c2, c1);
        return {18'h0, k, j, c2, c1};
    endfunction

    task set_prog(input logic [2:0] n, input logic [31:0] c, v1, v2, input logic [2:0] nx);
        logic [11:0] b;
        b = `DSSEQ_OFF_SET_BASE + {5'h0, n, 4'h0};
        apb(1'b1, b, c);
        apb(1'b1, b + 12'h004, v1);
        apb(1'b1, b + 12'h008, v2);
        apb(1'b1, b + 12'h00C, {16'h1234, 5'h0, n, 5'h0, nx});
    endtask

    // Wait for a launch, then compare set, type and target
    task expect_go(input logic [2:0] s, input logic [1:0] k);
        int i;
        for (i = 0; i < 24; i++)
        begin
            @(negedge ref_clk);
            if (move_go === 1'b1)
                break;
        end
        if (i == 24)
        begin
            fails++;
            results();
        end
        chk({29'h0, move_set}, {29'h0, s});
        chk({30'h0, move_kind}, {30'h0, k});
        chk(move_target, {16'h1234, 5'h0, s, 8'h00});
    endtask

    task quiet(input int n);
        repeat (n)
        begin
            @(negedge ref_clk);
            chk({31'h0, move_go}, 32'h0);
        end
    endtask

    task drive(input logic st, input logic sp);
        @(posedge ref_clk);
        start_cmd <= st;
        step_cmd  <= sp;
    endtask

    initial
    begin
        {arst_n, psel, penable, pwrite, start_cmd, step_cmd} = 6'h00;
        {paddr, pwdata, fails, samples_checked} = '0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        rchk(`DSSEQ_OFF_ACCEL, 32'h2710);
        rchk(`DSSEQ_OFF_DECEL, 32'h2710);
        rchk(`DSSEQ_OFF_GEAR_NUM, 32'h2);
        rchk(`DSSEQ_OFF_GEAR_DEN, 32'h1);
        apb(1'b1, `DSSEQ_OFF_ACCEL, 32'h0);
        rchk(`DSSEQ_OFF_ACCEL, 32'h2710);
        apb(1'b1, `DSSEQ_OFF_ACCEL, 32'hEA60);
        apb(1'b1, `DSSEQ_OFF_ACCEL, 32'hEA61);
        rchk(`DSSEQ_OFF_ACCEL, 32'hEA60);
        chk({16'h0, move_accel}, 32'hEA60);
        apb(1'b1, `DSSEQ_OFF_DECEL, 32'h1);
        rchk(`DSSEQ_OFF_DECEL, 32'h1);
        chk({16'h0, move_decel}, 32'h1);
        apb(1'b1, `DSSEQ_OFF_GEAR_NUM, 32'h0);
        rchk(`DSSEQ_OFF_GEAR_NUM, 32'h2);
        chk({16'h0, move_gear_num}, 32'h2);
        apb(1'b1, `DSSEQ_OFF_GEAR_DEN, 32'hFFFF);
        rchk(`DSSEQ_OFF_GEAR_DEN, 32'hFFFF);
        chk({16'h0, move_gear_den}, 32'hFFFF);
        rchk(12'h050, 32'h0);
        chk({31'h0, er}, 32'h1);
        set_prog(3'h0, cf(2'h1, 4'h0, 4'h0, 4'h0), 32'h0, 32'h0, 3'h1);
        set_prog(3'h1, cf(2'h2, 4'h0, 4'h0, 4'h1), 32'h3, 32'h0, 3'h2);
        set_prog(3'h2, cf(2'h1, 4'h0, 4'h0, 4'h2), 32'h0, 32'h0, 3'h3);
        set_prog(3'h3, cf(2'h2, 4'h0, 4'h0, 4'h3), 32'h3, 32'h0, 3'h4);
        set_prog(3'h4, cf(2'h1, 4'h1, 4'h3, 4'h1), 32'h2, 32'h4, 3'h5);
        set_prog(3'h5, cf(2'h2, 4'h2, 4'h3, 4'h1), 32'hFFFF, 32'h4, 3'h6);
        set_prog(3'h6, cf(2'h1, 4'h0, 4'h3, 4'h2), 32'h2, 32'h3, 3'h7);
        set_prog(3'h7, cf(2'h2, 4'h0, 4'h0, 4'h2), 32'h1, 32'h0, 3'h0);
        drive(1'b1, 1'b0);
        quiet(30);
        drive(1'b0, 1'b0);
        apb(1'b1, `DSSEQ_OFF_CTRL, 32'h0000_00C0);
        drive(1'b1, 1'b0);
        expect_go(3'h0, 2'h1);
        expect_go(3'h1, 2'h2);
        quiet(10);
        expect_go(3'h2, 2'h1);
        quiet(20);
        drive(1'b1, 1'b1);
        expect_go(3'h3, 2'h2);
        expect_go(3'h4, 2'h1);
        quiet(25);
        drive(1'b1, 1'b0);
        expect_go(3'h5, 2'h2);
        expect_go(3'h6, 2'h1);
        quiet(20);
        drive(1'b1, 1'b1);
        expect_go(3'h7, 2'h2);
        quiet(20);
        drive(1'b1, 1'b0);
        expect_go(3'h0, 2'h1);
        expect_go(3'h1, 2'h2);
        drive(1'b0, 1'b0);
        quiet(30);
        chk({31'h0, move_run}, 32'h0);
        apb(1'b1, `DSSEQ_OFF_SET_BASE, cf(2'h0, 4'h0, 4'h0, 4'h0));
        drive(1'b1, 1'b0);
        quiet(30);
        chk({31'h0, move_run}, 32'h0);
        drive(1'b0, 1'b0);
        apb(1'b1, `DSSEQ_OFF_SET_BASE, cf(2'h1, 4'h2, 4'h3, 4'h2));
        apb(1'b1, `DSSEQ_OFF_SET_BASE + 12'h004, 32'h5);
        apb(1'b1, `DSSEQ_OFF_SET_BASE + 12'h008, 32'h5);
        apb(1'b1, `DSSEQ_OFF_CTRL, 32'h0000_00C1);
        drive(1'b1, 1'b0);
        quiet(30);
        chk({31'h0, move_run}, 32'h0);
        drive(1'b0, 1'b0);
        apb(1'b1, `DSSEQ_OFF_CTRL, 32'h0000_00C0);
        drive(1'b1, 1'b0);
        expect_go(3'h0, 2'h1);
        drive(1'b1, 1'b1);
        quiet(20);
        drive(1'b1, 1'b0);
        quiet(20);
        chk({31'h0, move_run}, 32'h1);
        results();
    end
endmodule
